// ### logic/vptl_pkg.sv
// Purpose: Shared constants and types for the voted parameter table loader.
// Assumes: One 10 MHz clock and byte-wide table entries.
// Notes: Table copies sit at one offset inside separate EEPROM pages.
package vptl_pkg;
   localparam int TABLE_DEPTH = 64;
   localparam int REPORT_SEL_IDX = 0;
   localparam int NUM_COPIES = 3;
   localparam int EE_AW = 17;
   localparam int DATA_AW = 16;
   localparam logic [14:0] PARAM_EE_OFS = 15'h7f80;
   localparam logic [1:0] COPY0_PAGE = 2'h1;
   localparam logic [1:0] LAST_COPY = 2'h2;
   localparam logic [15:0] TABLE_DATA_BASE = 16'h8300;
   localparam logic [1:0] RELOAD_VOTED = 2'h0;
   localparam logic [7:0] REPORT_CYCLIC = 8'hff;
   localparam logic [7:0] DEFAULT_BYTE = 8'h00;
   localparam logic [7:0] DEFAULT_COUNT = 8'h00;
   localparam logic [7:0] COUNT_STEP = 8'h01;
   localparam logic [7:0] LFC_RESET = 8'hfe;
   localparam logic [7:0] EC_VOTE_MINOR = 8'h31;
   localparam logic [7:0] EC_VOTE_FATAL = 8'h32;
   localparam logic [7:0] EC_STORE_NOT_PROM = 8'h33;
   localparam logic [7:0] EC_BUSY = 8'h34;

   // Controller states.
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_DEF = 4'h1,
      S_LD_WAIT = 4'h2,
      S_LD_VOTE = 4'h3,
      S_ST_DLY = 4'h4,
      S_ST_GET = 4'h5,
      S_ST_EE = 4'h6,
      S_HK_DLY = 4'h7,
      S_HK_GET = 4'h8
   } vptl_state_e;
endpackage : vptl_pkg

// ### logic/vptl_tbl_if.sv
// Purpose: Carries table RAM and voter signals between the loader modules.
// Assumes: Port a belongs to the controller, port b to the dump reader.
// Notes: Read data on both ports come from registers in the RAM.
`timescale 1ns/10ps
`default_nettype none
interface vptl_tbl_if #(parameter int AW = 6, parameter int W = 8);
   logic [AW-1:0] a_addr;
   logic a_we;
   logic [W-1:0] a_wdata;
   logic [W-1:0] a_rdata;
   logic [AW-1:0] b_addr;
   logic [W-1:0] b_rdata;
   logic [W-1:0] v_a;
   logic [W-1:0] v_b;
   logic [W-1:0] v_c;
   logic [W-1:0] v_res;
   logic v_all;
   logic v_two;
   modport ram (input a_addr, a_we, a_wdata, b_addr, output a_rdata, b_rdata);
   modport vote (input v_a, v_b, v_c, output v_res, v_all, v_two);
   modport ctl (output a_addr, a_we, a_wdata, b_addr, v_a, v_b, v_c,
                input a_rdata, b_rdata, v_res, v_all, v_two);
endinterface : vptl_tbl_if
`default_nettype wire

// ### logic/vptl_table_ram.sv
// Purpose: Working parameter table storage with two registered read ports.
// Assumes: Contents are undefined until the controller fills them.
// Notes: Port b only reads, so a dump never disturbs a running load.
`timescale 1ns/10ps
`default_nettype none
module vptl_table_ram #(parameter int DEPTH = 64, parameter int W = 8) (
   input wire logic clk,
   vptl_tbl_if.ram tb
);
   logic [W-1:0] mem [DEPTH];

   // Write and read on port a, read on port b; read data are registered.
   always_ff @(posedge clk) begin
      if (tb.a_we) begin
         mem[tb.a_addr] <= tb.a_wdata;
      end
      tb.a_rdata <= mem[tb.a_addr];
      tb.b_rdata <= mem[tb.b_addr];
   end
endmodule : vptl_table_ram
`default_nettype wire

// ### logic/vptl_voter.sv
// Purpose: Three-way majority vote over one table byte.
// Assumes: Inputs are stable while the controller samples the result.
// Notes: With no majority the result is meaningless and must not be used.
`timescale 1ns/10ps
`default_nettype none
module vptl_voter (
   vptl_tbl_if.vote tb
);
   logic ab;
   logic ac;
   logic bc;

   // Compare pairs, then pick the value backed by at least two copies.
   assign ab = (tb.v_a == tb.v_b);
   assign ac = (tb.v_a == tb.v_c);
   assign bc = (tb.v_b == tb.v_c);
   assign tb.v_all = ab && ac;
   assign tb.v_two = (ab || ac || bc) && !(ab && ac);
   assign tb.v_res = (ab || ac) ? tb.v_a : tb.v_b;
endmodule : vptl_voter
`default_nettype wire

// ### logic/vptl_loader.sv
// Purpose: Keeps the working parameter table and moves it to and from EEPROM.
// Assumes: EEPROM accesses are level requests closed by a one-cycle ack.
// Notes: One table access at a time; commands that find it busy are refused, except reloads and packet requests, which wait.
`timescale 1ns/10ps
`default_nettype none
module vptl_loader #(
   parameter int DEPTH = vptl_pkg::TABLE_DEPTH,
   parameter int SEL_IDX = vptl_pkg::REPORT_SEL_IDX
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_write_param_entry,
   input wire logic [7:0] cmd_entry_index,
   input wire logic [7:0] cmd_entry_value,
   input wire logic cmd_persist_param_table,
   input wire logic cmd_reload_param_table,
   input wire logic [1:0] cmd_reload_copy_sel,
   input wire logic cmd_load_defaults,
   input wire logic exec_from_prom,
   input wire logic hk_packet_req,
   output logic hk_valid,
   output logic [7:0] reported_param_byte,
   output logic [7:0] reported_param_index,
   output logic [7:0] last_failure_code,
   output logic force_safe,
   output logic cmd_rejected,
   output logic busy,
   output logic ee_rd,
   output logic ee_wr,
   output logic [vptl_pkg::EE_AW-1:0] ee_addr,
   output logic [7:0] ee_wdata,
   input wire logic [7:0] ee_rdata,
   input wire logic ee_ack,
   input wire logic dump_rd,
   input wire logic [vptl_pkg::DATA_AW-1:0] dump_addr,
   output logic dump_valid,
   output logic [7:0] dump_rdata
);
   localparam int IDX_W = $clog2(DEPTH);
   localparam logic [IDX_W-1:0] LAST = IDX_W'(DEPTH - 1);
   localparam logic [IDX_W-1:0] SEL_AT = IDX_W'(SEL_IDX);

   // The last entry holds the store count and cannot also be the selection,
   // and the whole table must fit between the fixed offset and the page end.
   if (DEPTH < 4 || DEPTH > int'(~vptl_pkg::PARAM_EE_OFS) + 1 || SEL_IDX >= DEPTH - 1) begin : g_bad_cfg
      $error("vptl_loader: DEPTH or SEL_IDX out of range");
   end

   typedef struct packed {
      vptl_pkg::vptl_state_e state;
      logic boot;
      logic dir;
      logic [1:0] copy;
      logic [IDX_W-1:0] idx;
      logic [7:0] c0;
      logic [7:0] c1;
      logic [7:0] c2;
      logic [IDX_W-1:0] ram_addr;
      logic ram_we;
      logic [7:0] ram_wdata;
      logic ee_rd;
      logic ee_wr;
      logic [vptl_pkg::EE_AW-1:0] ee_addr;
      logic [7:0] ee_wdata;
      logic [7:0] lfc;
      logic [7:0] sel;
      logic [IDX_W-1:0] cyc;
      logic [7:0] rep_byte;
      logic [7:0] rep_idx;
      logic hk_valid;
      logic safe;
      logic rej;
      logic rl_pend;
      logic [1:0] rl_sel;
      logic hk_pend;
      logic dump_valid;
   } vptl_st_s;

   vptl_st_s r;
   vptl_st_s n;
   logic dump_hit;
   logic [vptl_pkg::DATA_AW-1:0] dump_ofs;

   vptl_tbl_if #(.AW(IDX_W), .W(8)) tb ();

   vptl_table_ram #(.DEPTH(DEPTH), .W(8)) u_ram (
      .clk(clk),
      .tb(tb.ram)
   );

   vptl_voter u_vote (
      .tb(tb.vote)
   );

   // EEPROM location of one entry of one copy: same offset, page per copy.
   function automatic logic [vptl_pkg::EE_AW-1:0] ee_loc(input logic [1:0] copy,
                                                        input logic [IDX_W-1:0] idx);
      logic [1:0] page;
      logic [14:0] ofs;
      page = 2'(vptl_pkg::COPY0_PAGE + copy);
      ofs = 15'(vptl_pkg::PARAM_EE_OFS + 15'(idx));
      return {page, ofs};
   endfunction : ee_loc

   // Built-in default for an entry; the selection starts out cyclic.
   function automatic logic [7:0] default_byte(input logic [IDX_W-1:0] idx);
      if (idx == SEL_AT) begin
         return vptl_pkg::REPORT_CYCLIC;
      end else if (idx == LAST) begin
         return vptl_pkg::DEFAULT_COUNT;
      end
      return vptl_pkg::DEFAULT_BYTE;
   endfunction : default_byte

   // Entry to report next, from the selection or the cyclic counter.
   function automatic logic [IDX_W-1:0] report_at(input logic [7:0] sel,
                                                  input logic [IDX_W-1:0] cyc);
      if (sel == vptl_pkg::REPORT_CYCLIC) begin
         return cyc;
      end
      return sel[IDX_W-1:0];
   endfunction : report_at

   // Memory dump window at the fixed data address of the working table.
   assign dump_ofs = dump_addr - vptl_pkg::TABLE_DATA_BASE;
   assign dump_hit = (dump_addr >= vptl_pkg::TABLE_DATA_BASE) && (dump_ofs < 16'(DEPTH));
   assign tb.b_addr = dump_ofs[IDX_W-1:0];
   assign dump_rdata = tb.b_rdata;

   // Controller port of the RAM and voter inputs straight from state.
   assign tb.a_addr = r.ram_addr;
   assign tb.a_we = r.ram_we;
   assign tb.a_wdata = r.ram_wdata;
   assign tb.v_a = r.c0;
   assign tb.v_b = r.c1;
   assign tb.v_c = r.c2;

   // Next state. Pulses drop by default; refused and pending commands are
   // settled after the state case so a request in a busy cycle is never lost.
   always_comb begin
      logic ld_next;
      logic took_w;
      logic took_p;
      logic took_d;
      logic took_rl;
      logic took_hk;
      logic [7:0] sbyte;
      logic [1:0] rsel;
      ld_next = 1'b0;
      took_w = 1'b0;
      took_p = 1'b0;
      took_d = 1'b0;
      took_rl = 1'b0;
      took_hk = 1'b0;
      sbyte = 8'h00;
      rsel = r.rl_pend ? r.rl_sel : cmd_reload_copy_sel;
      n = r;
      n.ram_we = 1'b0;
      n.hk_valid = 1'b0;
      n.safe = 1'b0;
      n.rej = 1'b0;
      n.dump_valid = dump_rd && dump_hit;
      case (r.state)
         vptl_pkg::S_IDLE: begin
            if (r.rl_pend || cmd_reload_param_table) begin
               took_rl = !r.rl_pend;
               n.rl_pend = 1'b0;
               n.dir = (rsel != vptl_pkg::RELOAD_VOTED);
               n.copy = (rsel != vptl_pkg::RELOAD_VOTED) ? 2'(rsel - 2'h1) : 2'h0;
               n.idx = '0;
               n.ee_rd = 1'b1;
               n.ee_addr = ee_loc(n.copy, '0);
               n.state = vptl_pkg::S_LD_WAIT;
            end else if (cmd_persist_param_table) begin
               took_p = 1'b1;
               if (exec_from_prom) begin
                  n.idx = '0;
                  n.ram_addr = '0;
                  n.state = vptl_pkg::S_ST_DLY;
               end else begin
                  n.rej = 1'b1;
                  n.lfc = vptl_pkg::EC_STORE_NOT_PROM;
               end
            end else if (cmd_load_defaults) begin
               took_d = 1'b1;
               n.idx = '0;
               n.state = vptl_pkg::S_DEF;
            end else if (cmd_write_param_entry) begin
               // Indices past the table are dropped quietly rather than refused as busy.
               took_w = 1'b1;
               if (cmd_entry_index < 8'(DEPTH)) begin
                  n.ram_we = 1'b1;
                  n.ram_addr = cmd_entry_index[IDX_W-1:0];
                  n.ram_wdata = cmd_entry_value;
               end
            end else if (r.hk_pend || hk_packet_req) begin
               took_hk = !r.hk_pend;
               n.hk_pend = 1'b0;
               n.ram_addr = report_at(r.sel, r.cyc);
               n.state = vptl_pkg::S_HK_DLY;
            end
         end
         vptl_pkg::S_DEF: begin
            n.ram_we = 1'b1;
            n.ram_addr = r.idx;
            n.ram_wdata = default_byte(r.idx);
            if (r.idx != LAST) begin
               n.idx = IDX_W'(r.idx + 1'b1);
            end else if (r.boot) begin
               // After reset the defaults stand until the voted load, and remain at entries where no two copies agree.
               n.boot = 1'b0;
               n.dir = 1'b0;
               n.copy = 2'h0;
               n.idx = '0;
               n.ee_rd = 1'b1;
               n.ee_addr = ee_loc(2'h0, '0);
               n.state = vptl_pkg::S_LD_WAIT;
            end else begin
               n.state = vptl_pkg::S_IDLE;
            end
         end
         vptl_pkg::S_LD_WAIT: begin
            if (ee_ack) begin
               n.ee_rd = 1'b0;
               if (r.dir) begin
                  n.ram_we = 1'b1;
                  n.ram_addr = r.idx;
                  n.ram_wdata = ee_rdata;
                  ld_next = 1'b1;
               end else begin
                  case (r.copy)
                     2'h0: n.c0 = ee_rdata;
                     2'h1: n.c1 = ee_rdata;
                     default: n.c2 = ee_rdata;
                  endcase
                  if (r.copy == vptl_pkg::LAST_COPY) begin
                     n.state = vptl_pkg::S_LD_VOTE;
                  end else begin
                     n.copy = 2'(r.copy + 2'h1);
                     n.ee_rd = 1'b1;
                     n.ee_addr = ee_loc(n.copy, r.idx);
                  end
               end
            end
         end
         vptl_pkg::S_LD_VOTE: begin
            ld_next = 1'b1;
            if (tb.v_all || tb.v_two) begin
               n.ram_we = 1'b1;
               n.ram_addr = r.idx;
               n.ram_wdata = tb.v_res;
               if (tb.v_two) begin
                  n.lfc = vptl_pkg::EC_VOTE_MINOR;
               end
            end else begin
               n.safe = 1'b1;
               n.lfc = vptl_pkg::EC_VOTE_FATAL;
            end
         end
         vptl_pkg::S_ST_DLY: begin
            n.state = vptl_pkg::S_ST_GET;
         end
         vptl_pkg::S_ST_GET: begin
            sbyte = tb.a_rdata;
            if (r.idx == LAST) begin
               // Count goes up first, so every copy and the RAM agree on it.
               sbyte = 8'(tb.a_rdata + vptl_pkg::COUNT_STEP);
               n.ram_we = 1'b1;
               n.ram_addr = r.idx;
               n.ram_wdata = sbyte;
            end
            n.ee_wdata = sbyte;
            n.copy = 2'h0;
            n.ee_wr = 1'b1;
            n.ee_addr = ee_loc(2'h0, r.idx);
            n.state = vptl_pkg::S_ST_EE;
         end
         vptl_pkg::S_ST_EE: begin
            if (ee_ack) begin
               if (r.copy != vptl_pkg::LAST_COPY) begin
                  n.copy = 2'(r.copy + 2'h1);
                  n.ee_addr = ee_loc(n.copy, r.idx);
               end else begin
                  n.ee_wr = 1'b0;
                  if (r.idx == LAST) begin
                     n.state = vptl_pkg::S_IDLE;
                  end else begin
                     n.idx = IDX_W'(r.idx + 1'b1);
                     n.ram_addr = n.idx;
                     n.state = vptl_pkg::S_ST_DLY;
                  end
               end
            end
         end
         vptl_pkg::S_HK_DLY: begin
            n.state = vptl_pkg::S_HK_GET;
         end
         vptl_pkg::S_HK_GET: begin
            n.rep_byte = tb.a_rdata;
            n.rep_idx = 8'(r.ram_addr);
            n.hk_valid = 1'b1;
            if (r.sel == vptl_pkg::REPORT_CYCLIC) begin
               n.cyc = (r.cyc == LAST) ? '0 : IDX_W'(r.cyc + 1'b1);
            end
            n.state = vptl_pkg::S_IDLE;
         end
         default: begin
            n.state = vptl_pkg::S_IDLE;
         end
      endcase
      // Step to the next entry of a load, or finish after the last one.
      if (ld_next) begin
         if (r.idx == LAST) begin
            n.state = vptl_pkg::S_IDLE;
         end else begin
            n.idx = IDX_W'(r.idx + 1'b1);
            n.copy = r.dir ? r.copy : 2'h0;
            n.ee_rd = 1'b1;
            n.ee_addr = ee_loc(n.copy, n.idx);
            n.state = vptl_pkg::S_LD_WAIT;
         end
      end
      // Any write of the selection entry retargets reporting.
      if (n.ram_we && n.ram_addr == SEL_AT) begin
         n.sel = n.ram_wdata;
      end
      // Requests that arrive while busy: reloads and packets wait, the rest are refused.
      if (cmd_reload_param_table && !took_rl) begin
         n.rl_pend = 1'b1;
         n.rl_sel = cmd_reload_copy_sel;
      end
      if (hk_packet_req && !took_hk) begin
         n.hk_pend = 1'b1;
      end
      if ((cmd_write_param_entry && !took_w) || (cmd_persist_param_table && !took_p) ||
          (cmd_load_defaults && !took_d)) begin
         n.rej = 1'b1;
         // A vote fault logged in the same cycle outranks a refused command.
         if (!(r.state == vptl_pkg::S_LD_VOTE && !tb.v_all)) begin
            n.lfc = vptl_pkg::EC_BUSY;
         end
      end
   end

   // State register; reset starts the default fill that precedes the boot load.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
         r.state <= vptl_pkg::S_DEF;
         r.boot <= 1'b1;
         r.lfc <= vptl_pkg::LFC_RESET;
         r.sel <= vptl_pkg::REPORT_CYCLIC;
      end else begin
         r <= n;
      end
   end

   assign hk_valid = r.hk_valid;
   assign reported_param_byte = r.rep_byte;
   assign reported_param_index = r.rep_idx;
   assign last_failure_code = r.lfc;
   assign force_safe = r.safe;
   assign cmd_rejected = r.rej;
   assign busy = (r.state != vptl_pkg::S_IDLE);
   assign ee_rd = r.ee_rd;
   assign ee_wr = r.ee_wr;
   assign ee_addr = r.ee_addr;
   assign ee_wdata = r.ee_wdata;
   assign dump_valid = r.dump_valid;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_STORE_NEEDS_PROM: assert property (
      (r.state == vptl_pkg::S_IDLE && !r.rl_pend && !cmd_reload_param_table && cmd_persist_param_table &&
       !exec_from_prom) |=> (cmd_rejected && !ee_wr && r.state == vptl_pkg::S_IDLE))
      else $error("store accepted outside PROM execution");
   AST_EE_WRITE_ONLY_IN_STORE: assert property (
      ee_wr |-> (r.state == vptl_pkg::S_ST_EE))
      else $error("EEPROM written outside a store");
   AST_FATAL_VOTE: assert property (
      (r.state == vptl_pkg::S_LD_VOTE && !tb.v_all && !tb.v_two) |=>
      (force_safe && last_failure_code == vptl_pkg::EC_VOTE_FATAL && !r.ram_we))
      else $error("three-way disagreement not handled");
   AST_MINOR_VOTE: assert property (
      (r.state == vptl_pkg::S_LD_VOTE && tb.v_two) |=>
      (last_failure_code == vptl_pkg::EC_VOTE_MINOR && r.ram_we && r.ram_wdata == $past(tb.v_res)))
      else $error("two-of-three vote not handled");
   AST_UNANIMOUS: assert property (
      (r.state == vptl_pkg::S_LD_VOTE && tb.v_all) |=> (r.ram_we && r.ram_wdata == $past(r.c0) && !force_safe))
      else $error("unanimous value not written");
   AST_COUNT_BUMP: assert property (
      (r.state == vptl_pkg::S_ST_GET && r.idx == LAST) |=>
      (r.ram_we && ee_wr && ee_wdata == 8'($past(tb.a_rdata) + vptl_pkg::COUNT_STEP)))
      else $error("store count not incremented");
   AST_EE_PAGE_OFS: assert property (
      (ee_rd || ee_wr) |-> (ee_addr[14:0] >= vptl_pkg::PARAM_EE_OFS && ee_addr[16:15] != 2'h0))
      else $error("EEPROM access outside the table area");
   AST_BOOT_LOAD: assert property (
      (r.state == vptl_pkg::S_DEF && r.boot && r.idx == LAST) |=>
      (r.state == vptl_pkg::S_LD_WAIT && ee_rd && !r.dir && ee_addr == ee_loc(2'h0, '0)))
      else $error("boot load did not follow default fill");
   AST_CYCLIC_REPORT: assert property (
      (r.state == vptl_pkg::S_HK_GET && r.sel == vptl_pkg::REPORT_CYCLIC) |=>
      (hk_valid && reported_param_index == 8'($past(r.cyc))))
      else $error("cyclic report index wrong");
endmodule : vptl_loader
`default_nettype wire

// ### dv/vptl_ee_model.sv
// Purpose: Behavioural model of the EEPROM array that holds the three table copies.
// Assumes: Level requests from the loader, closed by a one-cycle acknowledge.
// Notes: The read bus toggles every cycle between answers, so a stale byte never passes.
`timescale 1ns/10ps
`default_nettype none
module vptl_ee_model #(parameter int DEPTH = 8) (
   input wire logic clk,
   input wire logic rd,
   input wire logic wr,
   input wire logic [16:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [3:0] lat,
   output logic [7:0] rdata,
   output logic ack
);
   logic [7:0] mem [0:3][0:DEPTH-1];
   logic [3:0] cnt;
   logic [14:0] ofs;
   // Each copy sits at the same offset of its own page.
   assign ofs = addr[14:0] - vptl_pkg::PARAM_EE_OFS;
   initial begin
      cnt = 4'h0;
      ack = 1'b0;
      rdata = 8'h00;
   end
   // One access per acknowledge; lat wait cycles let the bench play slow or prompt.
   always @(posedge clk) begin
      ack <= 1'b0;
      rdata <= ~rdata;
      if ((rd || wr) && !ack) begin
         if (cnt >= lat) begin
            cnt <= 4'h0;
            ack <= 1'b1;
            if (wr) mem[addr[16:15]][int'(ofs)] <= wdata;
            else rdata <= mem[addr[16:15]][int'(ofs)];
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule : vptl_ee_model
`default_nettype wire

// ### dv/tb_voted_parameter_table_loader.sv
// Purpose: Self-checking bench for the loader against the EEPROM model.
// Assumes: Table depth cut to 8 entries to keep runs short.
// Notes: Inputs change on the falling edge so sampling never races.
`timescale 1ns/10ps
`default_nettype none
module tb_voted_parameter_table_loader;
   localparam int D = 8;
   logic clk, rst, wr_e, per, rel, defl, prom, hkr, drd, rd, wr, ack;
   logic [1:0] sel;
   logic [3:0] lat;
   logic [7:0] idx, val, hb, hi, lfc, wd, rdt, drdt;
   logic [16:0] ea;
   logic [15:0] da;
   logic hv, fs, rej, bsy, dv;
   int err_count, compares, safe_seen, rej_seen;
   logic [15:0] rows [5] = '{16'h00ff, 16'h0111, 16'h0222, 16'h0300, 16'h0700};
   vptl_loader #(.DEPTH(D), .SEL_IDX(0)) dut (.clk(clk), .rst(rst), .cmd_write_param_entry(wr_e),
      .cmd_entry_index(idx), .cmd_entry_value(val), .cmd_persist_param_table(per),
      .cmd_reload_param_table(rel), .cmd_reload_copy_sel(sel), .cmd_load_defaults(defl),
      .exec_from_prom(prom), .hk_packet_req(hkr), .hk_valid(hv), .reported_param_byte(hb),
      .reported_param_index(hi), .last_failure_code(lfc), .force_safe(fs), .cmd_rejected(rej),
      .busy(bsy), .ee_rd(rd), .ee_wr(wr), .ee_addr(ea), .ee_wdata(wd), .ee_rdata(rdt),
      .ee_ack(ack), .dump_rd(drd), .dump_addr(da), .dump_valid(dv), .dump_rdata(drdt));
   vptl_ee_model #(.DEPTH(D)) p (.clk(clk), .rd(rd), .wr(wr), .addr(ea), .wdata(wd), .lat(lat),
      .rdata(rdt), .ack(ack));
   // A 100 ns clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Pulse counters, since these outputs stand for a single cycle only; sampled mid-cycle.
   always @(negedge clk) begin
      if (fs === 1'b1) safe_seen++;
      if (rej === 1'b1) rej_seen++;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // Waits for idle with a bound; a hang counts as a mismatch.
   task automatic idle();
      for (int i = 0; i < 3000 && bsy !== 1'b0; i++) cyc(1);
      chk("busy", 8'h00, {7'h00, bsy});
   endtask : idle
   task automatic ram(input logic [7:0] i, input logic [7:0] e);
      drd = 1'b1;
      da = vptl_pkg::TABLE_DATA_BASE + {8'h00, i};
      cyc(1);
      drd = 1'b0;
      chk("dump_valid", 8'h01, {7'h00, dv});
      chk("dump_rdata", e, drdt);
      cyc(1);
   endtask : ram
   task automatic hk(input logic [7:0] ei, input logic [7:0] eb);
      hkr = 1'b1;
      cyc(1);
      hkr = 1'b0;
      cyc(2);
      chk("hk_valid", 8'h01, {7'h00, hv});
      chk("hk_index", ei, hi);
      chk("hk_byte", eb, hb);
   endtask : hk
   task automatic cmd(input logic [2:0] k);
      {rel, per, defl} = k;
      cyc(1);
      {rel, per, defl} = 3'h0;
   endtask : cmd
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      summarize();
   end
   initial begin
      {wr_e, per, rel, defl, prom, hkr, drd, sel, idx, val, da} = '0;
      err_count = 0;
      compares = 0;
      safe_seen = 0;
      rej_seen = 0;
      rst = 1'b1;
      lat = 4'h3;
      for (int k = 1; k < 4; k++) for (int i = 0; i < D; i++) p.mem[k][i] = 8'h00;
      for (int k = 1; k < 4; k++) {p.mem[k][0], p.mem[k][1], p.mem[k][3]} = {16'hff11, k[7:0]};
      {p.mem[1][2], p.mem[2][2], p.mem[3][2]} = 24'h225a22;
      repeat (5) @(posedge clk);
      cyc(1);
      chk("lfc_reset", vptl_pkg::LFC_RESET, lfc);
      rst = 1'b0;
      idle();
      foreach (rows[r]) ram(rows[r][15:8], rows[r][7:0]);
      chk("safe", 8'h01, safe_seen[7:0]);
      chk("lfc", vptl_pkg::EC_VOTE_FATAL, lfc);
      lat = 4'h0;
      hk(8'h00, 8'hff);
      hk(8'h01, 8'h11);
      {wr_e, idx, val} = {1'b1, 16'h0002};
      cyc(1);
      wr_e = 1'b0;
      cyc(2);
      hk(8'h02, 8'h22);
      cmd(3'h2);
      cyc(3);
      chk("rejected", 8'h01, rej_seen[7:0]);
      chk("lfc", vptl_pkg::EC_STORE_NOT_PROM, lfc);
      chk("copy", 8'hff, p.mem[1][0]);
      prom = 1'b1;
      cmd(3'h2);
      idle();
      cmd(3'h2);
      idle();
      for (int k = 1; k < 4; k++) begin
         chk("copy_sel", 8'h02, p.mem[k][0]);
         chk("copy_e2", 8'h22, p.mem[k][2]);
         chk("copy_cnt", 8'h02, p.mem[k][D-1]);
      end
      {wr_e, idx, val} = {1'b1, 16'h0177};
      cyc(1);
      wr_e = 1'b0;
      cyc(2);
      ram(8'h01, 8'h77);
      chk("copy_e1", 8'h11, p.mem[2][1]);
      p.mem[2][1] = 8'h99;
      sel = 2'h2;
      cmd(3'h4);
      idle();
      ram(8'h01, 8'h99);
      chk("lfc", vptl_pkg::EC_STORE_NOT_PROM, lfc);
      sel = vptl_pkg::RELOAD_VOTED;
      cmd(3'h4);
      idle();
      ram(8'h01, 8'h11);
      chk("lfc", vptl_pkg::EC_VOTE_MINOR, lfc);
      cmd(3'h1);
      // A write and a packet request during the fill: the write is refused, the packet waits.
      {wr_e, hkr, idx, val} = {2'h3, 16'h0155};
      cyc(1);
      {wr_e, hkr} = 2'h0;
      idle();
      cyc(3);
      chk("hk_pend_valid", 8'h01, {7'h00, hv});
      chk("hk_pend_index", 8'h02, hi);
      chk("hk_pend_byte", vptl_pkg::DEFAULT_BYTE, hb);
      chk("rejected_busy", 8'h02, rej_seen[7:0]);
      chk("lfc_busy", vptl_pkg::EC_BUSY, lfc);
      ram(8'h00, vptl_pkg::REPORT_CYCLIC);
      ram(8'h01, vptl_pkg::DEFAULT_BYTE);
      summarize();
   end
endmodule : tb_voted_parameter_table_loader
`default_nettype wire
